// File: design/transmitter_pin_function_mux.sv
// three-pin function multiplexer with apb registers and pin interrupts
//
// The implementer's own choice: the APB interface to the registers.
module transmitter_pin_function_mux #(
	parameter int unsigned PIN_COUNT   = 3,  // pins served by the register map
	parameter int unsigned SYNC_STAGES = 2   // input synchroniser depth
) (
	input  wire logic                                i_clock,                 // 50 mhz device clock
	input  wire logic                                i_nrst,                  // synchronous reset, active low
	input  wire logic                                i_psel,                  // apb select
	input  wire logic                                i_penable,               // apb enable
	input  wire logic                                i_pwrite,                // apb direction
	input  wire logic [pin_mux_pkg::ADDR_WIDTH-1:0]  i_paddr,                 // apb byte address
	input  wire logic [31:0]                         i_pwdata,                // apb write data
	output logic      [31:0]                         o_prdata,                // apb read data
	output logic                                     o_pready,                // apb ready
	output logic                                     o_pslverr,               // apb error
	input  wire logic [2:0]                          i_pin_in,                // pin levels
	output logic      [2:0]                          o_pin_out,               // pin drive level
	output logic      [2:0]                          o_pin_oe,                // pin driver enable
	output logic      [2:0]                          o_pin_analog,            // analog path connect
	output logic      [2:0]                          o_pin_pullup_enable,     // effective pull-ups
	output logic      [5:0]                          o_pin_drive_strength,    // two bits per pin
	input  wire logic                                i_por,                   // power-on reset flag
	input  wire logic                                i_wakeup_timer_expired,  // wake-up timer expired
	input  wire logic                                i_low_battery,           // battery below threshold
	input  wire logic                                i_mcu_clock,             // microcontroller clock
	input  wire logic                                i_tx_data_clock,         // transmit data clock
	input  wire logic                                i_tx_state,              // transmitter active
	input  wire logic                                i_tx_fifo_almost_full,   // fifo almost full
	output logic                                     o_tx_data,               // data taken from a pin
	output logic                                     o_retransmit_request,    // request taken from a pin
	input  wire logic                                i_serial_select_n,       // serial select, active low
	input  wire logic                                i_sdo_data,              // serial port output data
	input  wire logic                                i_sdo_oe,                // serial port output enable
	output logic                                     o_sdo,                   // serial data output pin
	output logic                                     o_sdo_oe,                // serial data output enable
	output logic                                     o_irq,                   // interrupt, active high
	output logic                                     o_irq_request_n          // interrupt request, active low
);

	// ************************************************************
	// elaboration check
	// ************************************************************
	if (PIN_COUNT != 3) begin : g_check
		$error("register map serves exactly three pins");
	end

	// ************************************************************
	// state
	// ************************************************************
	logic [7:0] pin_config [3];   // per-pin configuration
	logic [2:0] direct_io;        // direct output values
	logic       irq_on_sdo;       // route request to serial output
	logic [2:0] ext_flag;         // per-pin event flags
	logic       ext_enable;       // pin event interrupt enable

	// ************************************************************
	// input synchronisers
	// ************************************************************
	logic [2:0] pin_level;        // synchronised pin levels
	logic [2:0] pin_rise;         // rising edge pulses
	logic [2:0] pin_fall;         // falling edge pulses

	for (genvar p = 0; p < 3; p++) begin : g_sync
		pin_input_sync #(
			.STAGES  (SYNC_STAGES)
		) u_sync (
			.i_clock (i_clock),
			.i_nrst  (i_nrst),
			.i_pin   (i_pin_in[p]),
			.o_level (pin_level[p]),
			.o_rise  (pin_rise[p]),
			.o_fall  (pin_fall[p])
		);
	end

	// ************************************************************
	// apb decode
	// ************************************************************
	wire [7:0] word_index   = i_paddr[9:2];
	wire       upper_zero   = (i_paddr[pin_mux_pkg::ADDR_WIDTH-1:10] == '0);  // high bits must not alias an index
	wire       aligned      = upper_zero && (i_paddr[1:0] == pin_mux_pkg::WORD_OFFSET);
	wire       sel_status   = aligned && (word_index == pin_mux_pkg::INT_STATUS_INDEX);
	wire       sel_enable   = aligned && (word_index == pin_mux_pkg::INT_ENABLE_INDEX);
	wire       sel_cfg0     = aligned && (word_index == pin_mux_pkg::PIN0_CONFIG_INDEX);
	wire       sel_cfg1     = aligned && (word_index == pin_mux_pkg::PIN1_CONFIG_INDEX);
	wire       sel_cfg2     = aligned && (word_index == pin_mux_pkg::PIN2_CONFIG_INDEX);
	wire       sel_port     = aligned && (word_index == pin_mux_pkg::PORT_IO_INDEX);
	wire       mapped       = sel_status | sel_enable | sel_cfg0 | sel_cfg1 | sel_cfg2 | sel_port;
	wire       access       = i_psel & i_penable;
	wire       complete     = access & o_pready;
	wire       do_write     = complete & i_pwrite & mapped;
	wire       status_read  = complete & ~i_pwrite & sel_status;

	// ************************************************************
	// per-pin function decode
	// ************************************************************
	wire [4:0] code [3];
	wire [2:0] is_direct_in;      // pin read back as direct input
	wire [2:0] is_digital_in;     // any digital input function
	wire [2:0] pin_event;         // qualified interrupt edge
	wire [2:0] is_tx_data;        // pin feeds transmit data
	wire [2:0] is_retransmit;     // pin feeds retransmit request
	wire [2:0] own_zero_level;    // code-zero output per pin

	assign own_zero_level[0] = i_por;
	assign own_zero_level[1] = ~i_por;
	assign own_zero_level[2] = i_mcu_clock;

	for (genvar p = 0; p < 3; p++) begin : g_decode
		assign code[p]          = pin_config[p][pin_mux_pkg::FUNC_MSB:0];
		assign is_direct_in[p]  = (code[p] == pin_mux_pkg::FN_DIRECT_IN);
		assign is_tx_data[p]    = (code[p] == pin_mux_pkg::FN_TX_DATA);
		assign is_retransmit[p] = (code[p] == pin_mux_pkg::FN_RETRANSMIT);
		assign is_digital_in[p] = is_direct_in[p] | is_tx_data[p] | is_retransmit[p]
			| (code[p] == pin_mux_pkg::FN_EXT_FALL) | (code[p] == pin_mux_pkg::FN_EXT_RISE)
			| (code[p] == pin_mux_pkg::FN_EXT_CHANGE);
		// edge selection by interrupt flavour
		assign pin_event[p] = ((code[p] == pin_mux_pkg::FN_EXT_FALL) & pin_fall[p])
			| ((code[p] == pin_mux_pkg::FN_EXT_RISE) & pin_rise[p])
			| ((code[p] == pin_mux_pkg::FN_EXT_CHANGE) & (pin_rise[p] | pin_fall[p]));
	end

	// ************************************************************
	// pin driver selection
	// ************************************************************
	// returns {driver enable, level, analog connect}
	function automatic logic [2:0] pin_drive(input logic [4:0] fn, input logic zero_level, input logic dio);
		logic [2:0] result;
		result = 3'h0;
		case (fn)
			pin_mux_pkg::FN_SPECIAL:     result = {1'b1, zero_level, 1'b0};
			pin_mux_pkg::FN_WAKEUP:      result = {1'b1, i_wakeup_timer_expired, 1'b0};
			pin_mux_pkg::FN_LOW_BATTERY: result = {1'b1, i_low_battery, 1'b0};
			// inputs and test functions except FN_TEST_DIG leave the driver off
			pin_mux_pkg::FN_DIRECT_IN, pin_mux_pkg::FN_EXT_FALL, pin_mux_pkg::FN_EXT_RISE,
			pin_mux_pkg::FN_EXT_CHANGE, pin_mux_pkg::FN_TX_DATA, pin_mux_pkg::FN_RETRANSMIT,
			pin_mux_pkg::FN_TEST_N_IN, pin_mux_pkg::FN_TEST_P_IN, pin_mux_pkg::FN_TEST_N_OUT,
			pin_mux_pkg::FN_TEST_P_OUT:  result = 3'h0;
			// analog paths, digital driver off
			pin_mux_pkg::FN_ADC_IN,
			pin_mux_pkg::FN_VREF:        result = 3'h1;
			pin_mux_pkg::FN_DIRECT_OUT:  result = {1'b1, dio, 1'b0};
			pin_mux_pkg::FN_TX_CLOCK:    result = {1'b1, i_tx_data_clock, 1'b0};
			pin_mux_pkg::FN_TX_STATE:    result = {1'b1, i_tx_state, 1'b0};
			pin_mux_pkg::FN_FIFO_AFULL:  result = {1'b1, i_tx_fifo_almost_full, 1'b0};
			pin_mux_pkg::FN_HIGH:        result = 3'h6;
			// reserved and unlisted codes drive low
			default:                     result = 3'h4;
		endcase
		return result;
	endfunction

	wire [2:0] drive [3];
	wire [2:0] next_pin_out;
	wire [2:0] next_pin_oe;
	wire [2:0] next_pin_analog;
	wire [2:0] next_pullup;
	wire [5:0] next_drive_strength;

	for (genvar p = 0; p < 3; p++) begin : g_drive
		assign drive[p]           = pin_drive(code[p], own_zero_level[p], direct_io[p]);
		assign next_pin_oe[p]     = drive[p][2];
		assign next_pin_out[p]    = drive[p][1];
		assign next_pin_analog[p] = drive[p][0];
		assign next_pullup[p]     = pin_config[p][pin_mux_pkg::PULLUP_BIT] & is_digital_in[p];
		assign next_drive_strength[2*p+1:2*p] =
			pin_config[p][pin_mux_pkg::DRIVE_MSB:pin_mux_pkg::DRIVE_LSB];
	end

	// ************************************************************
	// interrupt flags
	// ************************************************************
	// read clears only while enabled; write-one clears too; new events win
	wire       clear_by_read  = status_read & ext_enable;
	wire       clear_by_write = do_write & sel_status & i_pwdata[pin_mux_pkg::EXT_INT_BIT];
	wire       flag_clear     = clear_by_read | clear_by_write;
	wire [2:0] next_ext_flag  = (ext_flag & ~{3{flag_clear}}) | pin_event;
	wire       next_ext_en    = (do_write & sel_enable) ? i_pwdata[pin_mux_pkg::EXT_INT_BIT] : ext_enable;
	wire       next_irq       = (|next_ext_flag) & next_ext_en;
	wire       next_sdo_irq   = irq_on_sdo & i_serial_select_n;

	// ************************************************************
	// read data selection
	// ************************************************************
	wire [2:0] dio_read = (is_direct_in & pin_level) | (~is_direct_in & direct_io);
	wire [7:0] port_read = {1'b0, ext_flag, irq_on_sdo, dio_read};
	wire [7:0] status_read_value = {4'h0, |ext_flag, 3'h0};
	wire [7:0] enable_read_value = {4'h0, ext_enable, 3'h0};
	wire [7:0] read_byte = sel_status ? status_read_value
		: sel_enable ? enable_read_value
		: sel_cfg0   ? pin_config[0]
		: sel_cfg1   ? pin_config[1]
		: sel_cfg2   ? pin_config[2]
		: sel_port   ? port_read
		: 8'h00;

	// ************************************************************
	// apb handshake, one wait state
	// ************************************************************
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			o_pready  <= 1'b0;
			o_prdata  <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= access & ~o_pready;
			if (access && !o_pready) begin
				o_prdata  <= {24'h00_0000, read_byte};
				o_pslverr <= ~mapped;
			end
		end
	end

	// ************************************************************
	// register writes
	// ************************************************************
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			pin_config[0] <= pin_mux_pkg::CONFIG_RESET;
			pin_config[1] <= pin_mux_pkg::CONFIG_RESET;
			pin_config[2] <= pin_mux_pkg::CONFIG_RESET;
			direct_io     <= pin_mux_pkg::PORT_RESET[2:0];
			irq_on_sdo    <= pin_mux_pkg::PORT_RESET[pin_mux_pkg::IRQ_ON_SDO_BIT];
		end else if (do_write) begin
			if (sel_cfg0) begin
				pin_config[0] <= i_pwdata[7:0];
			end
			if (sel_cfg1) begin
				pin_config[1] <= i_pwdata[7:0];
			end
			if (sel_cfg2) begin
				pin_config[2] <= i_pwdata[7:0];
			end
			if (sel_port) begin
				direct_io  <= i_pwdata[2:0];
				irq_on_sdo <= i_pwdata[pin_mux_pkg::IRQ_ON_SDO_BIT];
			end
		end
	end

	// ************************************************************
	// interrupt state
	// ************************************************************
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			ext_flag   <= 3'h0;
			ext_enable <= pin_mux_pkg::ENABLE_RESET;
		end else begin
			ext_flag   <= next_ext_flag;
			ext_enable <= next_ext_en;
		end
	end

	// ************************************************************
	// registered pin and system outputs
	// ************************************************************
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			o_pin_out            <= 3'h0;
			o_pin_oe             <= 3'h0;
			o_pin_analog         <= 3'h0;
			o_pin_pullup_enable  <= 3'h0;
			o_pin_drive_strength <= 6'h00;
			o_tx_data            <= 1'b0;
			o_retransmit_request <= 1'b0;
			o_irq                <= 1'b0;
			o_irq_request_n      <= 1'b1;
			o_sdo                <= 1'b0;
			o_sdo_oe             <= 1'b0;
		end else begin
			o_pin_out            <= next_pin_out;
			o_pin_oe             <= next_pin_oe;
			o_pin_analog         <= next_pin_analog;
			o_pin_pullup_enable  <= next_pullup;
			o_pin_drive_strength <= next_drive_strength;
			o_tx_data            <= |(is_tx_data & pin_level);
			o_retransmit_request <= |(is_retransmit & pin_level);
			o_irq                <= next_irq;
			o_irq_request_n      <= ~next_irq;
			// serial output carries the request only while deselected
			o_sdo                <= next_sdo_irq ? ~next_irq : i_sdo_data;
			o_sdo_oe             <= next_sdo_irq | i_sdo_oe;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	pready_pulse_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		o_pready |=> !o_pready)
		else $error("ready held longer than one cycle");

	access_wait_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		access && !o_pready |=> o_pready)
		else $error("ready not given after one wait state");

	fixed_high_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		code[0] == pin_mux_pkg::FN_HIGH |=> o_pin_out[0] && o_pin_oe[0])
		else $error("constant-high code not driven high");

	analog_off_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		code[2] == pin_mux_pkg::FN_ADC_IN || code[2] == pin_mux_pkg::FN_VREF |=> !o_pin_oe[2] && o_pin_analog[2])
		else $error("analog function left the driver on");

	pullup_gate_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		o_pin_pullup_enable[0] |-> $past(is_digital_in[0]) && $past(pin_config[0][pin_mux_pkg::PULLUP_BIT]))
		else $error("pull-up active outside digital input");

	ext_status_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		pin_event[1] |=> ext_flag[1])
		else $error("pin event not recorded");

	irq_enable_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		!ext_enable && !(do_write && sel_enable) |=> o_irq_request_n && !o_irq)
		else $error("request asserted while disabled");

	read_release_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		clear_by_read && pin_event == 3'h0 |=> o_irq_request_n ##1 (ext_flag == 3'h0 || $past(|pin_event)))
		else $error("status read did not release the request");

	sdo_route_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		irq_on_sdo && i_serial_select_n |=> o_sdo_oe && (o_sdo == o_irq_request_n))
		else $error("request missing on serial output");

	direct_out_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		code[1] == pin_mux_pkg::FN_DIRECT_OUT |=> o_pin_oe[1] && (o_pin_out[1] == $past(direct_io[1])))
		else $error("direct output does not follow its bit");

	power_on_out_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		code[0] == pin_mux_pkg::FN_SPECIAL |=> o_pin_oe[0] && (o_pin_out[0] == $past(i_por)))
		else $error("pin 0 does not show power-on reset");

	inverted_reset_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		code[1] == pin_mux_pkg::FN_SPECIAL |=> o_pin_oe[1] && (o_pin_out[1] == !$past(i_por)))
		else $error("pin 1 does not show inverted power-on reset");

	fall_event_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		code[0] == pin_mux_pkg::FN_EXT_FALL && $fell(pin_level[0]) |=> ext_flag[0])
		else $error("falling edge not recorded");

	tx_data_in_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		is_tx_data == 3'h2 |=> o_tx_data == $past(pin_level[1]))
		else $error("transmit data not taken from its pin");

endmodule

// File: design/pin_mux_pkg.sv
// constants, field layout and function codes of the three-pin function multiplexer
// How it works
// - codes 1 and 2 output wake-up and battery
// - pin 0 code 0 outputs power-on reset
// - pin 1 code 0 outputs inverted power-on reset
// - pin 2 code 0 outputs microcontroller clock
// - code 3 direct input, code 10 direct output
// - codes 4,5,6 falling, rising, any-edge interrupt
// - per-pin interrupt status at port bits 6:4
// - direct bits drive outputs, read back inputs
// - port bit 3 puts interrupt on serial output
// - pull-up bit 5 only for digital inputs
// - code 15 data clock out, 16 data in
// - codes 17,18,19 retransmit, tx state, almost full
// - code 29 high, others low, 20-28 reserved
// - codes 7 and 14 analog, driver off
// - bits 7:6 drive strength to pin driver
// - pin events request interrupt only when enabled
// - request low on enabled set, released on read
package pin_mux_pkg;

	// ************************************************************
	// register indices and byte addresses
	// ************************************************************
	localparam logic [7:0]  INT_STATUS_INDEX   = 8'h03;  // interrupt status
	localparam logic [7:0]  INT_ENABLE_INDEX   = 8'h05;  // interrupt enable
	localparam logic [7:0]  PIN0_CONFIG_INDEX  = 8'h0B;  // pin 0 configuration
	localparam logic [7:0]  PIN1_CONFIG_INDEX  = 8'h0C;  // pin 1 configuration
	localparam logic [7:0]  PIN2_CONFIG_INDEX  = 8'h0D;  // pin 2 configuration
	localparam logic [7:0]  PORT_IO_INDEX      = 8'h0E;  // port register
	localparam int unsigned ADDR_WIDTH         = 12;     // apb address width
	localparam logic [1:0]  WORD_OFFSET        = 2'h0;   // byte offset within a word

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int unsigned DRIVE_MSB          = 7;      // drive strength field
	localparam int unsigned DRIVE_LSB          = 6;
	localparam int unsigned PULLUP_BIT         = 5;      // pull-up enable
	localparam int unsigned FUNC_MSB           = 4;      // function select field
	localparam int unsigned EXT_STATUS_LSB     = 4;      // port: pin event flags
	localparam int unsigned IRQ_ON_SDO_BIT     = 3;      // port: irq on serial out
	localparam int unsigned EXT_INT_BIT        = 3;      // status and enable bit
	localparam logic [7:0]  CONFIG_RESET       = 8'h00;
	localparam logic [7:0]  PORT_RESET         = 8'h00;
	localparam logic        ENABLE_RESET       = 1'h0;

	// ************************************************************
	// pin function codes
	// ************************************************************
	typedef enum logic [4:0] {
		FN_SPECIAL     = 5'h00,  // per-pin: reset, inverted reset, clock
		FN_WAKEUP      = 5'h01,  // wake-up timer expired
		FN_LOW_BATTERY = 5'h02,  // battery below threshold
		FN_DIRECT_IN   = 5'h03,  // direct digital input
		FN_EXT_FALL    = 5'h04,  // interrupt on falling edge
		FN_EXT_RISE    = 5'h05,  // interrupt on rising edge
		FN_EXT_CHANGE  = 5'h06,  // interrupt on any change
		FN_ADC_IN      = 5'h07,  // analog input to converter
		FN_TEST_N_IN   = 5'h08,  // test functions
		FN_TEST_P_IN   = 5'h09,
		FN_DIRECT_OUT  = 5'h0A,  // direct digital output
		FN_TEST_DIG    = 5'h0B,
		FN_TEST_N_OUT  = 5'h0C,
		FN_TEST_P_OUT  = 5'h0D,
		FN_VREF        = 5'h0E,  // reference voltage out
		FN_TX_CLOCK    = 5'h0F,  // transmit data clock out
		FN_TX_DATA     = 5'h10,  // transmit data in
		FN_RETRANSMIT  = 5'h11,  // retransmission request in
		FN_TX_STATE    = 5'h12,  // transmit state out
		FN_FIFO_AFULL  = 5'h13,  // fifo almost full out
		FN_HIGH        = 5'h1D   // constant high
	} pin_function_e;

endpackage

// File: design/pin_input_sync.sv
// synchroniser and edge detector for one pin input
module pin_input_sync #(
	parameter int unsigned STAGES = 2  // synchroniser depth
) (
	input  wire logic i_clock,   // device clock
	input  wire logic i_nrst,    // synchronous reset, active low
	input  wire logic i_pin,     // raw pin level
	output logic      o_level,   // synchronised level
	output logic      o_rise,    // one-cycle rising edge
	output logic      o_fall     // one-cycle falling edge
);

	// ************************************************************
	// elaboration check
	// ************************************************************
	if (STAGES < 2) begin : g_check
		$error("pin_input_sync needs at least two stages");
	end

	logic [STAGES-1:0] sync;   // synchroniser chain
	logic              prev;   // last synchronised level

	// ************************************************************
	// chain and edge history
	// ************************************************************
	// first stage feeds only the second; edges look at the last stage
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			sync <= '0;
			prev <= 1'b0;
		end else begin
			sync <= {sync[STAGES-2:0], i_pin};
			prev <= sync[STAGES-1];
		end
	end

	assign o_level = sync[STAGES-1];
	assign o_rise  = sync[STAGES-1] & ~prev;
	assign o_fall  = ~sync[STAGES-1] & prev;

endmodule

// File: dv/pin_board_model.sv
// board-side model of the three pins: external drivers, pull-ups and floating lines
module pin_board_model (
	input  wire logic       i_clock,    // device clock
	input  wire logic [2:0] i_out,      // device drive level
	input  wire logic [2:0] i_oe,       // device driver enable
	input  wire logic [2:0] i_pullup,   // effective pull-ups
	input  wire logic [2:0] i_ext_en,   // board drives the pin
	input  wire logic [2:0] i_ext_val,  // board drive level
	output logic      [2:0] o_level     // resulting pin level
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] float_q = 3'h5;  // undriven lines wander every cycle
	always_ff @(posedge i_clock) float_q <= ~float_q;
	// device driver first, then board driver, then pull-up or a wandering level
	assign o_level = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val) | (~i_oe & ~i_ext_en & (i_pullup | float_q));
endmodule

// File: dv/tb_transmitter_pin_function_mux.sv
// self-checking bench of the three-pin function multiplexer
module tb_transmitter_pin_function_mux;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] OE = 32'hFFFC_8C07, PUP = 32'h0003_0078, ANA = 32'h0000_4080;  // per-code expectations
	logic i_clock = 1'h0, i_nrst = 1'h0, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0, i_serial_select_n = 1'h0;
	logic [pin_mux_pkg::ADDR_WIDTH-1:0] i_paddr = '0;
	logic [31:0] i_pwdata = '0, o_prdata, rd;
	logic [6:0] src = '0, prv = '0;  // status sources, and as the pins show them
	logic [2:0] ext_en = '0, ext_val = '0, dv, i_pin_in, o_pin_out, o_pin_oe, o_pin_analog, o_pin_pullup_enable;
	logic [5:0] o_pin_drive_strength;
	logic [7:0] cfg;
	logic i_por, i_wakeup_timer_expired, i_low_battery, i_mcu_clock, i_tx_data_clock, i_tx_state, i_tx_fifo_almost_full;
	logic i_sdo_data = 1'h0, i_sdo_oe = 1'h0, o_pready, o_pslverr, o_tx_data, o_retransmit_request, o_sdo, o_sdo_oe;
	logic o_irq, o_irq_request_n, err;
	int failures = 0, compares = 0, p;
	assign {i_por, i_wakeup_timer_expired, i_low_battery, i_mcu_clock} = src[6:3];
	assign {i_tx_data_clock, i_tx_state, i_tx_fifo_almost_full} = src[2:0];
	transmitter_pin_function_mux DUT (.i_clock, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
		.o_pready, .o_pslverr, .i_pin_in, .o_pin_out, .o_pin_oe, .o_pin_analog, .o_pin_pullup_enable, .o_pin_drive_strength,
		.i_por, .i_wakeup_timer_expired, .i_low_battery, .i_mcu_clock, .i_tx_data_clock, .i_tx_state, .i_tx_fifo_almost_full,
		.o_tx_data, .o_retransmit_request, .i_serial_select_n, .i_sdo_data, .i_sdo_oe, .o_sdo, .o_sdo_oe, .o_irq, .o_irq_request_n);
	pin_board_model board (.i_clock, .i_out(o_pin_out), .i_oe(o_pin_oe), .i_pullup(o_pin_pullup_enable), .i_ext_en(ext_en),
		.i_ext_val(ext_val), .o_level(i_pin_in));
	initial forever #10 i_clock = ~i_clock;
	// random status sources and serial port traffic every cycle
	always @(posedge i_clock) begin
		src <= 7'($urandom);
		prv <= src;
		{i_sdo_data, i_sdo_oe} <= 2'($urandom);
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one apb transfer: setup, access until ready, then one idle edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		{i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'h1, w, a, 24'h0, d};
		@(posedge i_clock);
		i_penable <= 1'h1;
		do @(posedge i_clock); while (o_pready !== 1'h1);
		{rd, err} = {o_prdata, o_pslverr};
		{i_psel, i_penable} <= 2'h0;
		@(posedge i_clock);
	endtask
	task automatic give_verdict;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// level a driven pin shows for a function code
	function automatic logic exp_out(input int p, input logic [4:0] c, input logic [6:0] s, input logic d);
		case (c)
			5'h00: return p == 2 ? s[3] : s[6] ^ (p == 1);
			5'h01: return s[5];
			5'h02: return s[4];
			5'h0A: return d;
			5'h0F: return s[2];
			5'h12: return s[1];
			5'h13: return s[0];
			default: return c == 5'h1D;
		endcase
	endfunction
	initial begin
		p = $urandom(32'hA21E);
		repeat (16) @(posedge i_clock);
		i_nrst <= 1'h1;
		for (int i = 0; i < 36; i++) begin
			p = i < 4 ? 0 : $urandom_range(2);
			dv = 3'($urandom);
			cfg = i < 4 ? 8'h00 : {3'($urandom), 5'(i - 4)};
			if (i < 4) apb(1'h0, 12'h02C + 12'(4 * i), 8'h00);
			if (i < 4) chk("reset", rd, 32'h0);
			if (i >= 4) apb(1'h1, 12'h038, {5'h00, dv});
			apb(1'h1, 12'h02C + 12'(4 * p), cfg);
			apb(1'h0, 12'h02C + 12'(4 * p), 8'h00);
			chk("config", rd, {24'h0, cfg});
			chk("drive", o_pin_drive_strength[2 * p+:2], cfg[7:6]);
			chk("pullup", o_pin_pullup_enable[p], cfg[5] & PUP[cfg[4:0]]);
			chk("analog", o_pin_analog[p], ANA[cfg[4:0]]);
			chk("enable", o_pin_oe[p], OE[cfg[4:0]]);
			if (OE[cfg[4:0]]) chk("level", o_pin_out[p], exp_out(p, cfg[4:0], prv, dv[p]));
		end
		// board drives every pin high; quiet input codes, then clear flags left by the sweep
		{ext_en, ext_val} <= 6'h3F;
		apb(1'h1, 12'h02C, 8'h03);
		apb(1'h1, 12'h030, 8'h10);
		apb(1'h1, 12'h034, 8'h11);
		apb(1'h1, 12'h00C, 8'h08);
		repeat (3) @(posedge i_clock);
		apb(1'h0, 12'h038, 8'h00);
		chk("direct in", {rd[6:4], rd[0]}, 4'h1);
		chk("tx inputs", {o_tx_data, o_retransmit_request}, 2'h3);
		apb(1'h1, 12'h02C, 8'h04);
		ext_val <= 3'h0;
		repeat (6) @(posedge i_clock);
		chk("masked", {o_irq_request_n, o_tx_data, o_retransmit_request}, 3'h4);
		apb(1'h0, 12'h038, 8'h00);
		chk("flag", rd[6:4], 3'h1);
		i_serial_select_n <= 1'h1;
		apb(1'h1, 12'h038, 8'h08);
		apb(1'h1, 12'h014, 8'h08);
		repeat (2) @(posedge i_clock);
		chk("irq", {o_irq, o_irq_request_n, o_sdo_oe, o_sdo}, 4'hA);
		apb(1'h0, 12'h00C, 8'h00);
		chk("status", rd, 32'h8);
		chk("release", o_irq_request_n, 1'h1);
		apb(1'h1, 12'h030, 8'h06);
		ext_val <= 3'h2;
		repeat (6) @(posedge i_clock);
		chk("change irq", o_irq_request_n, 1'h0);
		apb(1'h0, 12'h038, 8'h00);
		chk("change flag", rd[6:4], 3'h2);
		apb(1'h0, 12'h100, 8'h00);
		chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge i_clock);
		failures++;
		give_verdict();
	end
endmodule
